// ### can_diag_cfg.svh
// constants for the can-fd error state and diagnostics block
`ifndef CAN_DIAG_CFG_SVH
`define CAN_DIAG_CFG_SVH

// register byte offsets
`define ERR_COUNT_STATE_OFS 8'h00
`define RATE_SPLIT_OFS 8'h04
`define KIND_FLAGS_OFS 8'h08

// error count register fields
`define TX_BUS_OFF_FLAG_BIT 21
`define TX_ERROR_PASSIVE_FLAG_BIT 20
`define RX_ERROR_PASSIVE_FLAG_BIT 19
`define TX_WARNING_FLAG_BIT 18
`define RX_WARNING_FLAG_BIT 17
`define ANY_WARNING_FLAG_BIT 16

// error kind flags and good count register fields
`define DLC_MISMATCH_BIT 31
`define ESI_BIT 30
`define FAST_KIND_LSB 24
`define BUS_OFF_EVENT_BIT 23
`define NOMINAL_KIND_LSB 16
`define KIND_FLAGS_WMASK 32'hfbbf_ffff

// fault confinement limits
`define WARN_LOW 9'h05f
`define WARN_HIGH 9'h080
`define PASSIVE_LIMIT 9'h07f
`define BUS_OFF_LIMIT 9'h0ff
`define TX_ERR_STEP 9'h008
`define REC_PASSIVE_RELOAD 8'h7f

`endif

// ### can_diag_pkg.sv
// types shared by the can-fd error state and diagnostics block
package can_diag_pkg;

   // one-hot error kind, bit order matches the flag fields
   typedef enum logic [5:0] {
      KIND_BIT0 = 6'h01,
      KIND_BIT1 = 6'h02,
      KIND_ACK = 6'h04,
      KIND_FORM = 6'h08,
      KIND_STUFF = 6'h10,
      KIND_CRC = 6'h20
   } err_kind_e;

   typedef struct packed {
      logic valid;
      logic is_tx;
      logic fast_phase;
      err_kind_e kind;
   } err_event_s;

   typedef struct packed {
      logic valid;
      logic is_tx;
   } msg_ok_s;

endpackage : can_diag_pkg

// ### can_fd_error_state_diagnostics.sv
// error state tracking and bus diagnostics registers of a can-fd node
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps

`include "can_diag_cfg.svh"

module can_fd_error_state_diagnostics
   import can_diag_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // protocol engine events
   input wire logic config_mode_i,
   input wire err_event_s err_event_i,
   input wire msg_ok_s msg_ok_i,
   input wire logic recessive_run11_i,
   input wire logic recovery_done_i,
   input wire logic dlc_mismatch_i,
   input wire logic esi_seen_i,
   // error state
   output logic [7:0] tx_error_count_o,
   output logic [7:0] rx_error_count_o,
   output logic tx_bus_off_flag_o,
   output logic tx_error_passive_flag_o,
   output logic rx_error_passive_flag_o,
   output logic any_warning_flag_o
);

   // ************************************************************
   // saturating helpers
   // ************************************************************

   function automatic logic [7:0] sat_inc8(input logic [7:0] v);
      sat_inc8 = (v == 8'hff) ? v : v + 8'h01;
   endfunction : sat_inc8

   function automatic logic [15:0] sat_inc16(input logic [15:0] v);
      sat_inc16 = (v == 16'hffff) ? v : v + 16'h0001;
   endfunction : sat_inc16

   // ************************************************************
   // state
   // ************************************************************

   // tec keeps a ninth bit so that 256 marks bus-off
   logic [8:0] tec_reg;
   logic [8:0] tec_next;
   logic [7:0] rec_reg;
   logic [7:0] rec_next;
   logic tx_bus_off_flag_reg;
   logic tx_error_passive_flag_reg;
   logic rx_error_passive_flag_reg;
   logic tx_warning_flag_reg;
   logic rx_warning_flag_reg;
   logic any_warning_flag_reg;
   logic tx_bus_off_flag_next;
   logic tx_error_passive_flag_next;
   logic rx_error_passive_flag_next;
   logic tx_warning_flag_next;
   logic rx_warning_flag_next;
   logic [31:0] rate_split_error_counts_reg;
   logic [31:0] rate_split_error_counts_next;
   logic [31:0] kind_flags_reg;
   logic [31:0] kind_flags_next;
   logic [31:0] wb_dat_reg;
   logic [31:0] wb_dat_next;
   logic wb_ack_reg;

   // ************************************************************
   // event decode
   // ************************************************************

   wire logic in_bus_off = tec_reg > `BUS_OFF_LIMIT;
   // error and good-message events are meaningless off the bus, so they are dropped there
   wire logic on_bus = ~config_mode_i & ~in_bus_off;
   wire logic ev_ok = err_event_i.valid & on_bus;
   wire logic ev_tx = ev_ok & err_event_i.is_tx;
   wire logic ev_rx = ev_ok & ~err_event_i.is_tx;
   wire logic ev_fast = ev_ok & err_event_i.fast_phase;
   wire logic ev_nominal = ev_ok & ~err_event_i.fast_phase;
   wire logic ok_tx = msg_ok_i.valid & msg_ok_i.is_tx & on_bus;
   wire logic ok_rx = msg_ok_i.valid & ~msg_ok_i.is_tx & on_bus;
   wire logic ok_any = ok_tx | ok_rx;
   wire logic recovered = recovery_done_i & in_bus_off & ~config_mode_i;
   wire logic run11 = recessive_run11_i & in_bus_off;
   wire logic [5:0] ev_kind = err_event_i.kind;

   // ack error has no data-phase field, that bit stays zero
   wire logic [5:0] fast_kind_set =
      ev_fast ? (ev_kind & 6'h3b) : 6'h00;
   wire logic [5:0] nominal_kind_set =
      (ev_nominal ? ev_kind : 6'h00) | {5'h00, run11};

   wire logic [31:0] kind_set = {
      dlc_mismatch_i,
      esi_seen_i,
      fast_kind_set,
      recovered,
      1'b0,
      nominal_kind_set,
      16'h0000
   };

   // ************************************************************
   // bus slave decode
   // ************************************************************

   wire logic wb_req = wb_cyc_i & wb_stb_i;
   // writes land on the edge that carries ack, as the master expects
   wire logic wb_wr_fire = wb_req & wb_we_i & wb_ack_reg;
   wire logic sel_error_count = wb_adr_i[7:2] == `ERR_COUNT_STATE_OFS >> 2;
   wire logic sel_rate_split = wb_adr_i[7:2] == `RATE_SPLIT_OFS >> 2;
   wire logic sel_kind_flags = wb_adr_i[7:2] == `KIND_FLAGS_OFS >> 2;
   wire logic wr_rate_split = wb_wr_fire & sel_rate_split;
   wire logic wr_kind_flags = wb_wr_fire & sel_kind_flags;
   wire logic [31:0] byte_mask = {
      {8{wb_sel_i[3]}},
      {8{wb_sel_i[2]}},
      {8{wb_sel_i[1]}},
      {8{wb_sel_i[0]}}
   };

   wire logic [31:0] error_count_state = {
      10'h000,
      tx_bus_off_flag_reg,
      tx_error_passive_flag_reg,
      rx_error_passive_flag_reg,
      tx_warning_flag_reg,
      rx_warning_flag_reg,
      any_warning_flag_reg,
      tec_reg[7:0],
      rec_reg
   };

   // unmapped offsets read as zero and still get an ack
   wire logic [31:0] read_mux =
      sel_error_count ? error_count_state :
      sel_rate_split ? rate_split_error_counts_reg :
      sel_kind_flags ? kind_flags_reg :
      32'h0000_0000;

   // ************************************************************
   // fault confinement counts
   // ************************************************************

   always_comb begin
      tec_next = tec_reg;
      rec_next = rec_reg;
      if (config_mode_i) begin
         tec_next = 9'h000;
         rec_next = 8'h00;
      end else if (recovered) begin
         tec_next = 9'h000;
         rec_next = 8'h00;
      end else if (ev_tx) begin
         // saturate at the bus-off mark
         if (tec_reg > `BUS_OFF_LIMIT - `TX_ERR_STEP) begin
            tec_next = `BUS_OFF_LIMIT + 9'h001;
         end else begin
            tec_next = tec_reg + `TX_ERR_STEP;
         end
      end else if (ev_rx) begin
         rec_next = sat_inc8(rec_reg);
      end else if (ok_tx) begin
         if (tec_reg != 9'h000) begin
            tec_next = tec_reg - 9'h001;
         end
      end else if (ok_rx) begin
         if ({1'b0, rec_reg} > `PASSIVE_LIMIT) begin
            rec_next = `REC_PASSIVE_RELOAD;
         end else if (rec_reg != 8'h00) begin
            rec_next = rec_reg - 8'h01;
         end
      end
   end

   // ************************************************************
   // derived state flags, taken from the next counts
   // ************************************************************

   always_comb begin
      tx_bus_off_flag_next =
         (tec_next > `BUS_OFF_LIMIT) | config_mode_i;
      tx_error_passive_flag_next = tec_next > `PASSIVE_LIMIT;
      rx_error_passive_flag_next =
         {1'b0, rec_next} > `PASSIVE_LIMIT;
      tx_warning_flag_next =
         (tec_next > `WARN_LOW) & (tec_next < `WARN_HIGH);
      rx_warning_flag_next = ({1'b0, rec_next} > `WARN_LOW) &
         ({1'b0, rec_next} < `WARN_HIGH);
   end

   // ************************************************************
   // rate split counters
   // ************************************************************

   always_comb begin
      rate_split_error_counts_next = rate_split_error_counts_reg;
      if (wr_rate_split) begin
         rate_split_error_counts_next =
            (wb_dat_i & byte_mask) |
            (rate_split_error_counts_reg & ~byte_mask);
      end
      // a counted error in a write cycle adds onto the written value
      if (ev_fast & ev_tx) begin
         rate_split_error_counts_next[31:24] =
            sat_inc8(rate_split_error_counts_next[31:24]);
      end
      if (ev_fast & ev_rx) begin
         rate_split_error_counts_next[23:16] =
            sat_inc8(rate_split_error_counts_next[23:16]);
      end
      if (ev_nominal & ev_tx) begin
         rate_split_error_counts_next[15:8] =
            sat_inc8(rate_split_error_counts_next[15:8]);
      end
      if (ev_nominal & ev_rx) begin
         rate_split_error_counts_next[7:0] =
            sat_inc8(rate_split_error_counts_next[7:0]);
      end
   end

   // ************************************************************
   // sticky error kinds and good message count
   // ************************************************************

   always_comb begin
      kind_flags_next = kind_flags_reg;
      if (wr_kind_flags) begin
         kind_flags_next = ((wb_dat_i & byte_mask) |
            (kind_flags_reg & ~byte_mask)) & `KIND_FLAGS_WMASK;
      end
      // hardware set wins over a clearing write in the same cycle
      kind_flags_next = kind_flags_next | kind_set;
      if (ok_any) begin
         kind_flags_next[15:0] = sat_inc16(kind_flags_next[15:0]);
      end
   end

   // ************************************************************
   // bus answer
   // ************************************************************

   always_comb begin
      wb_dat_next = wb_dat_reg;
      if (wb_req & ~wb_ack_reg) begin
         wb_dat_next = read_mux;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tec_reg <= 9'h000;
         rec_reg <= 8'h00;
      end else begin
         tec_reg <= tec_next;
         rec_reg <= rec_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // the bus-off flag reads set during reset and clears on the first clock unless config_mode_i is high
         tx_bus_off_flag_reg <= 1'b1;
         tx_error_passive_flag_reg <= 1'b0;
         rx_error_passive_flag_reg <= 1'b0;
         tx_warning_flag_reg <= 1'b0;
         rx_warning_flag_reg <= 1'b0;
         any_warning_flag_reg <= 1'b0;
      end else begin
         tx_bus_off_flag_reg <= tx_bus_off_flag_next;
         tx_error_passive_flag_reg <= tx_error_passive_flag_next;
         rx_error_passive_flag_reg <= rx_error_passive_flag_next;
         tx_warning_flag_reg <= tx_warning_flag_next;
         rx_warning_flag_reg <= rx_warning_flag_next;
         any_warning_flag_reg <=
            tx_warning_flag_next | rx_warning_flag_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_split_error_counts_reg <= 32'h0000_0000;
         kind_flags_reg <= 32'h0000_0000;
      end else begin
         rate_split_error_counts_reg <= rate_split_error_counts_next;
         kind_flags_reg <= kind_flags_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_reg <= 1'b0;
         wb_dat_reg <= 32'h0000_0000;
      end else begin
         // one wait state, ack drops the cycle after it was given
         wb_ack_reg <= wb_req & ~wb_ack_reg;
         wb_dat_reg <= wb_dat_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************

   assign wb_ack_o = wb_ack_reg;
   assign wb_dat_o = wb_dat_reg;
   assign tx_error_count_o = tec_reg[7:0];
   assign rx_error_count_o = rec_reg;
   assign tx_bus_off_flag_o = tx_bus_off_flag_reg;
   assign tx_error_passive_flag_o = tx_error_passive_flag_reg;
   assign rx_error_passive_flag_o = rx_error_passive_flag_reg;
   assign any_warning_flag_o = any_warning_flag_reg;

endmodule : can_fd_error_state_diagnostics

// ### can_diag_asserts.sv
// checker for the error state and register bus ports
`timescale 1ns/1ps
module can_diag_asserts
   import can_diag_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // engine events
   input wire logic config_mode_i,
   input wire err_event_s err_event_i,
   input wire msg_ok_s msg_ok_i,
   input wire logic recovery_done_i,
   // error state
   input wire logic [7:0] tx_error_count_o,
   input wire logic [7:0] rx_error_count_o,
   input wire logic tx_bus_off_flag_o,
   input wire logic tx_error_passive_flag_o,
   input wire logic rx_error_passive_flag_o,
   input wire logic any_warning_flag_o
);
   // ********
   // properties
   // ********
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire quiet = !err_event_i.valid && !msg_ok_i.valid && !config_mode_i
      && !recovery_done_i;
   // single events only, so priority between sources plays no part
   wire live = !config_mode_i && !tx_bus_off_flag_o && !msg_ok_i.valid;
   wire [7:0] tec = tx_error_count_o;
   wire [7:0] rec = rx_error_count_o;
   bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
   cfg_bus_off_a: assert property (config_mode_i |=> tx_bus_off_flag_o
      && tec == 8'h00 && rec == 8'h00) else $error("config state wrong");
   tx_passive_a: assert property (!tx_bus_off_flag_o |->
      tx_error_passive_flag_o == (tec > 8'h7f)) else $error("tx passive");
   rx_passive_a: assert property (
      rx_error_passive_flag_o == (rec > 8'h7f)) else $error("rx passive");
   any_warn_a: assert property (any_warning_flag_o ==
      (tec inside {[8'h60:8'h7f]} || rec inside {[8'h60:8'h7f]}))
      else $error("warning flag wrong");
   rx_step_a: assert property (live && err_event_i.valid
      && !err_event_i.is_tx && rec != 8'hff
      |=> rec == $past(rec) + 8'h01) else $error("rx count step");
   tx_step_a: assert property (live && err_event_i.valid
      && err_event_i.is_tx |=> tx_bus_off_flag_o == ($past(tec) >= 8'hf8)
      && tec == (tx_bus_off_flag_o ? 8'h00 : $past(tec) + 8'h08))
      else $error("tx count step");
   count_hold_a: assert property (quiet |=> $stable(tec)
      && $stable(rec)) else $error("count moved");
   top_zero_a: assert property (wb_ack_o && !wb_we_i
      && wb_adr_i[7:2] == 6'h00 |-> wb_dat_o[31:22] == 10'h000)
      else $error("unused bits set");
   cover property (tx_bus_off_flag_o && !config_mode_i);
   cover property (rx_error_passive_flag_o);
   cover property (any_warning_flag_o);
endmodule : can_diag_asserts

bind can_fd_error_state_diagnostics can_diag_asserts u_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .config_mode_i(config_mode_i),
   .err_event_i(err_event_i), .msg_ok_i(msg_ok_i),
   .recovery_done_i(recovery_done_i),
   .tx_error_count_o(tx_error_count_o),
   .rx_error_count_o(rx_error_count_o),
   .tx_bus_off_flag_o(tx_bus_off_flag_o),
   .tx_error_passive_flag_o(tx_error_passive_flag_o),
   .rx_error_passive_flag_o(rx_error_passive_flag_o),
   .any_warning_flag_o(any_warning_flag_o));

// ### can_node_model.sv
// far side model that feeds bus events into the block
`timescale 1ns/1ps
module can_node_model
   import can_diag_pkg::*;
(
   // clock
   input wire logic clk_i,
   // bus events
   output err_event_s err_event_o,
   output msg_ok_s msg_ok_o,
   output logic [3:0] misc_o
);
   // ********
   // event pulses
   // ********
   initial begin
      err_event_o = '0;
      msg_ok_o = '0;
      misc_o = 4'h0;
   end
   // idle gap g lets the far side answer promptly or slowly
   task automatic send_err(input logic t, input logic f,
      input err_kind_e k, input int g);
      repeat (g) @(posedge clk_i);
      @(posedge clk_i);
      err_event_o <= '{1'b1, t, f, k};
      @(posedge clk_i);
      err_event_o <= '0;
   endtask : send_err
   task automatic send_ok(input logic t, input int g);
      repeat (g) @(posedge clk_i);
      @(posedge clk_i);
      msg_ok_o <= '{1'b1, t};
      @(posedge clk_i);
      msg_ok_o <= '0;
   endtask : send_ok
   task automatic pulse(input int i);
      @(posedge clk_i);
      misc_o[i] <= 1'b1;
      @(posedge clk_i);
      misc_o <= 4'h0;
   endtask : pulse
endmodule : can_node_model

// ### tb.sv
// self-checking bench for the error state and diagnostics block
`timescale 1ns/1ps
`include "can_diag_cfg.svh"
`define CMP(g, e) begin checks_done++; if ((g) !== (e)) begin \
   num_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
   import can_diag_pkg::*;
   // ********
   // signals and model state
   // ********
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, config_mode_i = 1'b0;
   err_event_s err_event_i;
   msg_ok_s msg_ok_i;
   logic [3:0] misc;
   logic [7:0] tx_error_count_o, rx_error_count_o;
   logic tx_bus_off_flag_o, tx_error_passive_flag_o;
   logic rx_error_passive_flag_o, any_warning_flag_o;
   int num_errors = 0, checks_done = 0, seed = 59652;
   int tec = 0, rec = 0, good = 0;
   int dc[4] = '{0, 0, 0, 0};
   logic [15:0] kf = 16'h0000;
   can_fd_error_state_diagnostics u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .config_mode_i(config_mode_i), .err_event_i(err_event_i),
      .msg_ok_i(msg_ok_i), .recessive_run11_i(misc[0]),
      .recovery_done_i(misc[1]), .dlc_mismatch_i(misc[2]),
      .esi_seen_i(misc[3]), .tx_error_count_o(tx_error_count_o),
      .rx_error_count_o(rx_error_count_o),
      .tx_bus_off_flag_o(tx_bus_off_flag_o),
      .tx_error_passive_flag_o(tx_error_passive_flag_o),
      .rx_error_passive_flag_o(rx_error_passive_flag_o),
      .any_warning_flag_o(any_warning_flag_o));
   can_node_model u_node (.clk_i(clk_i), .err_event_o(err_event_i),
      .msg_ok_o(msg_ok_i), .misc_o(misc));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   function automatic int sat(int v, int m);
      return v > m ? m : v;
   endfunction : sat
   function automatic logic [31:0] exp0();
      logic tw, rw;
      tw = tec > 95 && tec < 128;
      rw = rec > 95 && rec < 128;
      return {10'h000, config_mode_i || tec > 255, tec > 127, rec > 127,
         tw, rw, tw || rw, tec[7:0], rec[7:0]};
   endfunction : exp0
   task automatic wb_rw(input logic w, input logic [7:0] a,
      input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask : wb_rw
   task automatic check_out();
      logic [31:0] e;
      logic [19:0] g;
      e = exp0();
      #1;
      g = {tx_bus_off_flag_o, tx_error_passive_flag_o,
         rx_error_passive_flag_o, any_warning_flag_o, tx_error_count_o,
         rx_error_count_o};
      `CMP(g, {e[21:19], e[16:0]})
   endtask : check_out
   task automatic check_regs();
      logic [31:0] q;
      wb_rw(1'b0, `ERR_COUNT_STATE_OFS, 4'hf, 32'h0, q);
      `CMP(q, exp0())
      wb_rw(1'b0, `RATE_SPLIT_OFS, 4'hf, 32'h0, q);
      `CMP(q, {dc[3][7:0], dc[2][7:0], dc[1][7:0], dc[0][7:0]})
      wb_rw(1'b0, `KIND_FLAGS_OFS, 4'hf, 32'h0, q);
      `CMP(q, {kf, good[15:0]})
      wb_rw(1'b0, 8'h0c, 4'hf, 32'h0, q);
      `CMP(q, 32'h0)
   endtask : check_regs
   task automatic do_err(input logic t, input logic f, input int k);
      u_node.send_err(t, f, err_kind_e'(6'h01 << k), $random(seed) & 3);
      if (!config_mode_i && tec < 256) begin
         if (t)
            tec = sat(tec + 8, 256);
         else
            rec = sat(rec + 1, 255);
         dc[{f, t}] = sat(dc[{f, t}] + 1, 255);
         if (!(f && k == 2)) kf[k + (f ? 8 : 0)] = 1'b1;
      end
   endtask : do_err
   task automatic do_ok(input logic t);
      u_node.send_ok(t, $random(seed) & 3);
      if (t && tec > 0)
         tec--;
      else if (!t && rec > 127)
         rec = 127;
      else if (!t && rec > 0)
         rec--;
      good = sat(good + 1, 65535);
   endtask : do_ok
   task automatic misc_ev(input int i);
      u_node.pulse(i);
      if (i == 0 && tec > 255) kf[0] = 1'b1;
      if (i == 1 && tec > 255) {tec, rec, kf[7]} = {32'd0, 32'd0, 1'b1};
      if (i > 1) kf[17 - i] = 1'b1;
   endtask : misc_ev
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      logic [31:0] m, q, v;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      wb_rw(1'b1, a, s, d, q);
      v = {dc[3][7:0], dc[2][7:0], dc[1][7:0], dc[0][7:0]};
      v = (v & ~m) | (d & m);
      if (a == `RATE_SPLIT_OFS)
         for (int i = 0; i < 4; i++) dc[i] = v[8 * i +: 8];
      m = m & `KIND_FLAGS_WMASK;
      v = ({kf, good[15:0]} & ~m) | (d & m);
      if (a == `KIND_FLAGS_OFS) begin
         kf = v[31:16];
         good = v[15:0];
      end
   endtask : wr
   task automatic results();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // ********
   // main sequence
   // ********
   initial begin
      int r, k;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      `CMP(tx_bus_off_flag_o, 1'b1)
      check_regs();
      for (int i = 0; i < 300; i++) begin
         r = $random(seed) & 7;
         k = ($random(seed) & 7) % 6;
         if (r == 7 && tec < 256)
            do_ok(i >= 200);
         else
            do_err(i >= 200, r[0], k);
         check_out();
         if (i % 16 == 0) check_regs();
      end
      misc_ev(0);
      check_regs();
      for (int i = 1; i < 4; i++) misc_ev(i);
      check_regs();
      wr(`ERR_COUNT_STATE_OFS, $random(seed), 4'hf);
      wr(`RATE_SPLIT_OFS, $random(seed), $random(seed));
      wr(`KIND_FLAGS_OFS, $random(seed), $random(seed));
      check_regs();
      wr(`RATE_SPLIT_OFS, 32'h0, 4'hf);
      wr(`KIND_FLAGS_OFS, 32'h0, 4'hf);
      check_regs();
      @(posedge clk_i);
      config_mode_i <= 1'b1;
      {tec, rec} = 64'd0;
      do_err(1'b0, 1'b0, 0);
      check_regs();
      config_mode_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check_out();
      results();
   end
   initial begin
      #2000000;
      num_errors++;
      results();
   end
endmodule : tb
